/* clri_cfg.svh */
// constants for the clock reference interrupt status block
// assumes the includer wants plain defines; no logic lives here
`ifndef CLRI_CFG_SVH
`define CLRI_CFG_SVH
// register offsets on the serial port address space
`define CLRI_STATUS_OFS 7'h06
`define CLRI_FREQ_OFS 7'h07
// status byte field positions
`define CLRI_MODE_BIT 7
`define CLRI_REFLOST_BIT 6
`define CLRI_THIRD_BIT 0
// status byte reset value, unused bits 5:1 hold ones
`define CLRI_STATUS_RST 8'h3F
`define CLRI_UNUSED_ONES 5'h1F
// operating mode codes that block the ref-lost event
`define CLRI_MODE_FREERUN 3'h1
`define CLRI_MODE_HOLDOVER 3'h2
// missing cycles that declare the first-loop reference lost
`define CLRI_MISS_COUNT 2
// nominal reference period in ns and system clock period in ns
`define CLRI_REF_PERIOD_NS 125000
`define CLRI_CLK_PERIOD_NS 100
`define CLRI_REF_PERIOD_CYC (`CLRI_REF_PERIOD_NS / `CLRI_CLK_PERIOD_NS)
`endif

/* clri_pkg.sv */
// types shared by the clock reference interrupt status block
// assumes clri_cfg.svh supplies the numeric constants
package clri_pkg;
  // register access request from the serial port engine
  typedef struct packed {
    logic [6:0] addr; // register address
    logic wr; // one-cycle write strobe
    logic [7:0] wdata; // write data
  } clri_acc_s;
  // loop frequency top bits of both loops
  typedef struct packed {
    logic [2:0] first_loop; // first loop freq bits 18:16
    logic [2:0] second_loop; // second loop freq bits 18:16
  } clri_freq_s;
endpackage

/* clri_ref_monitor.sv */
// first-loop reference activity monitor
// assumes ref_clk_in is an asynchronous pin, sampled on clk_sys
`timescale 1ns/10ps
`include "clri_cfg.svh"
module clri_ref_monitor #(
  parameter int REF_PERIOD_CYC = `CLRI_REF_PERIOD_CYC,
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ref_clk_in,
  output logic miss_pulse
);
  // gap that means the configured number of cycles went missing, plus half a period
  localparam int MISS_LIM = REF_PERIOD_CYC * `CLRI_MISS_COUNT + REF_PERIOD_CYC / 2;
  localparam logic [CNT_W-1:0] LIM = CNT_W'(MISS_LIM);
  logic sync1_r; // first synchroniser stage
  logic sync2_r; // second synchroniser stage
  logic prev_r; // last sampled level for edge detect
  logic [CNT_W-1:0] gap_r; // cycles since last rising edge
  logic [CNT_W-1:0] gap_nxt;
  wire rise = sync2_r & ~prev_r; // reference rising edge
  wire at_lim = (gap_r == LIM); // gap hits the missing limit
  // count up, restart on edge, park just past the limit
  assign gap_nxt = rise ? '0 : (gap_r > LIM) ? gap_r : gap_r + CNT_W'(1);
  // one pulse per loss episode, without waiting for invalid
  assign miss_pulse = at_lim & ~rise;
  // synchroniser and gap counter
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
      gap_r <= '0;
    end else begin
      sync1_r <= ref_clk_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      gap_r <= gap_nxt;
    end
  end
endmodule

/* clri_int_status.sv */
// interrupt status byte (bits 15:8) and loop frequency readback
// assumes register access arrives from the serial port engine on clk_sys;
// mode, validity, select and frequency inputs come from logic on clk_sys
`timescale 1ns/10ps
`include "clri_cfg.svh"
module clri_int_status #(
  parameter int REF_PERIOD_CYC = `CLRI_REF_PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire clri_pkg::clri_acc_s acc,
  output logic [7:0] reg_rdata,
  input wire logic ref_clk_in,
  input wire logic [2:0] operating_mode,
  input wire logic third_clock_input_valid,
  input wire logic readback_loop_select,
  input wire clri_pkg::clri_freq_s loop_freq,
  output logic [7:0] status_flags
);
  import clri_pkg::*;

  logic mode_flag_r; // bit 7 latched mode change
  logic lost_flag_r; // bit 6 latched first-loop ref lost
  logic third_flag_r; // bit 0 latched third input change
  logic [2:0] mode_prev_r; // mode seen last cycle
  logic valid_prev_r; // third input validity last cycle
  logic [7:0] rdata_nxt; // read data for the next cycle
  logic miss_pulse; // reference monitor event
  logic hist_ok_r; // history holds real samples
  // reset byte kept as a vector so each flag takes its own bit
  localparam logic [7:0] STS_RST = `CLRI_STATUS_RST;

  // reference monitor for the first loop
  clri_ref_monitor #(
    .REF_PERIOD_CYC(REF_PERIOD_CYC),
    .CNT_W(16)
  ) u_mon (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ref_clk_in(ref_clk_in),
    .miss_pulse(miss_pulse)
  );

  // decode of writes to the status byte
  wire wr_sts = acc.wr & (acc.addr == `CLRI_STATUS_OFS);
  // only ones in the data clear; zeros leave flags alone
  wire clr_mode = wr_sts & acc.wdata[`CLRI_MODE_BIT];
  wire clr_lost = wr_sts & acc.wdata[`CLRI_REFLOST_BIT];
  wire clr_third = wr_sts & acc.wdata[`CLRI_THIRD_BIT];
  // ref lost blocked in free-run and holdover
  wire mode_blocks = (operating_mode == `CLRI_MODE_FREERUN) |
                     (operating_mode == `CLRI_MODE_HOLDOVER);
  wire set_lost = miss_pulse & ~mode_blocks;
  // change events wait for one real history sample, so reset gives no false edge
  wire set_third = hist_ok_r & (third_clock_input_valid ^ valid_prev_r);
  wire set_mode = hist_ok_r & (operating_mode != mode_prev_r);
  // status byte, unused bits 5:1 held at their reset ones
  assign status_flags = {mode_flag_r, lost_flag_r, `CLRI_UNUSED_ONES, third_flag_r};
  // frequency top bits from the selected loop, upper bits zero
  wire [2:0] freq_sel = readback_loop_select ? loop_freq.first_loop
                                             : loop_freq.second_loop;
  // read mux, unmapped addresses answer zero
  assign rdata_nxt = (acc.addr == `CLRI_STATUS_OFS) ? status_flags :
                     (acc.addr == `CLRI_FREQ_OFS) ? {5'h00, freq_sel} : 8'h00;

  // sticky flags, a set in the clear cycle wins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_flag_r <= STS_RST[`CLRI_MODE_BIT];
      lost_flag_r <= STS_RST[`CLRI_REFLOST_BIT];
      third_flag_r <= STS_RST[`CLRI_THIRD_BIT];
    end else begin
      mode_flag_r <= set_mode | (mode_flag_r & ~clr_mode);
      lost_flag_r <= set_lost | (lost_flag_r & ~clr_lost);
      third_flag_r <= set_third | (third_flag_r & ~clr_third);
    end
  end

  // history for change detection, captured after reset release
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_prev_r <= 3'h0;
      valid_prev_r <= 1'b0;
      hist_ok_r <= 1'b0;
    end else begin
      mode_prev_r <= operating_mode;
      valid_prev_r <= third_clock_input_valid;
      hist_ok_r <= 1'b1;
    end
  end

  // registered read data
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // blocked modes never raise the ref-lost flag
  a_lost_mode_block: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mode_blocks & ~lost_flag_r) |=> ~lost_flag_r)
    else $error("ref lost set in blocked mode");
  // a monitor event outside blocked modes latches next cycle
  a_lost_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    (miss_pulse && !mode_blocks) |=> lost_flag_r)
    else $error("ref lost event not latched");
  // validity toggle latches the third input flag
  a_third_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    hist_ok_r && $changed(third_clock_input_valid) |=> third_flag_r)
    else $error("third input change missed");
  // write one with no event clears the flag to zero
  a_third_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clr_third && !set_third) |=> !third_flag_r)
    else $error("third input flag not cleared");
  // mode flag stays set without a clearing write
  a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mode_flag_r && !clr_mode) |=> mode_flag_r [*1])
    else $error("mode flag dropped without clear");
  // mode change latches bit 7
  a_mode_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    hist_ok_r && $changed(operating_mode) |=> status_flags[7])
    else $error("mode change missed");
  // unused status bits read back as ones through the read path
  a_unused_ones: assert property (@(posedge clk_sys) disable iff (!nrst)
    (acc.addr == `CLRI_STATUS_OFS) |=> reg_rdata[5:1] == `CLRI_UNUSED_ONES)
    else $error("unused status bits wrong");
  // readback picks the selected loop one cycle later, top bits zero
  a_freq_read: assert property (@(posedge clk_sys) disable iff (!nrst)
    (acc.addr == `CLRI_FREQ_OFS) |=>
    reg_rdata == {5'h00, ($past(readback_loop_select) ? $past(loop_freq.first_loop)
                                                       : $past(loop_freq.second_loop))})
    else $error("frequency readback wrong");
  // a zero write leaves the lost flag alone
  a_zero_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr_sts && !acc.wdata[`CLRI_REFLOST_BIT] && lost_flag_r) |=> lost_flag_r)
    else $error("zero write cleared a flag");

  // checks on the clear, hold, quiet, read, set-wins, readback write and monitor event paths

  // write one with no event clears the lost flag
  a_lost_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clr_lost && !set_lost) |=> !lost_flag_r)
    else $error("ref lost flag not cleared");

  // write one with no event clears the mode flag
  a_mode_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clr_mode && !set_mode) |=> !mode_flag_r)
    else $error("mode flag not cleared");

  // lost flag holds until a clearing write
  a_lost_sticky: assert property (@(posedge clk_sys) disable iff (!nrst)
    (lost_flag_r && !clr_lost) |=> lost_flag_r)
    else $error("ref lost flag dropped without clear");

  // third input flag holds until a clearing write
  a_third_sticky: assert property (@(posedge clk_sys) disable iff (!nrst)
    (third_flag_r && !clr_third) |=> third_flag_r)
    else $error("third input flag dropped without clear");

  // a zero in bit 7 leaves the mode flag alone
  a_mode_zero_wr: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr_sts && !acc.wdata[`CLRI_MODE_BIT] && mode_flag_r) |=> mode_flag_r)
    else $error("zero write cleared the mode flag");

  // a zero in bit 0 leaves the third input flag alone
  a_third_zero_wr: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr_sts && !acc.wdata[`CLRI_THIRD_BIT] && third_flag_r) |=> third_flag_r)
    else $error("zero write cleared the third input flag");

  // status address returns the live byte one cycle later
  a_status_read: assert property (@(posedge clk_sys) disable iff (!nrst)
    (acc.addr == `CLRI_STATUS_OFS) |=> reg_rdata == $past(status_flags))
    else $error("status readback wrong");

  // unmapped addresses answer zero
  a_unmapped_read: assert property (@(posedge clk_sys) disable iff (!nrst)
    (acc.addr != `CLRI_STATUS_OFS && acc.addr != `CLRI_FREQ_OFS) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // no monitor event, no lost flag
  a_lost_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!lost_flag_r && !miss_pulse) |=> !lost_flag_r)
    else $error("ref lost flag set without event");

  // steady validity never raises the third input flag
  a_third_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!third_flag_r && $stable(third_clock_input_valid)) |=> !third_flag_r)
    else $error("third input flag set without change");

  // steady mode never raises the mode flag
  a_mode_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!mode_flag_r && $stable(operating_mode)) |=> !mode_flag_r)
    else $error("mode flag set without change");

  // unused readback bits read zero
  a_freq_top_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    (acc.addr == `CLRI_FREQ_OFS) |=> reg_rdata[7:3] == 5'h00)
    else $error("frequency readback upper bits not zero");

  // a loss event in the clearing cycle still latches
  a_lost_set_wins: assert property (@(posedge clk_sys) disable iff (!nrst)
    (set_lost && clr_lost) |=> lost_flag_r)
    else $error("clear beat a ref lost event");

  // a validity change in the clearing cycle still latches
  a_third_set_wins: assert property (@(posedge clk_sys) disable iff (!nrst)
    (set_third && clr_third) |=> third_flag_r)
    else $error("clear beat a third input change");

  // a mode change in the clearing cycle still latches
  a_mode_set_wins: assert property (@(posedge clk_sys) disable iff (!nrst)
    (set_mode && clr_mode) |=> mode_flag_r)
    else $error("clear beat a mode change");

  // writes to the readback address leave the status byte alone
  a_freq_wr_ignored: assert property (@(posedge clk_sys) disable iff (!nrst)
    (acc.wr && acc.addr == `CLRI_FREQ_OFS && !set_mode && !set_lost && !set_third) |=>
    status_flags == $past(status_flags))
    else $error("readback write touched the status byte");

  // one monitor event per loss episode
  a_miss_single: assert property (@(posedge clk_sys) disable iff (!nrst)
    miss_pulse |=> !miss_pulse)
    else $error("ref loss event repeated");
endmodule

/* clri_testbench.sv */
// self-checking bench for the interrupt status byte and the frequency readback
// assumes clri_int_status built with a short reference period; inputs move on falling clk
`timescale 1ns/10ps
module testbench;
  import clri_pkg::*;
  localparam int P = 8; // short reference period in clocks
  logic clk_sys = 1'b0; // 10 MHz system clock
  logic nrst = 1'b0; // active low reset
  clri_acc_s acc = '0; // register access request
  logic [7:0] reg_rdata; // registered read data
  logic ref_clk_in = 1'b0; // first loop reference pin
  logic ref_run = 1'b1; // reference generator enable
  logic [2:0] operating_mode = 3'h0; // mode code
  logic third_clock_input_valid = 1'b0; // third input validity
  logic readback_loop_select = 1'b0; // loop shown by the readback
  clri_freq_s loop_freq = '0; // top frequency bits of both loops
  logic [7:0] status_flags; // live status byte
  logic [7:0] rv; // last value read
  int failures = 0;
  int compares = 0;
  // clock, then a reference of P clocks that stops low
  always #50 clk_sys = ~clk_sys;
  always #(P*50) ref_clk_in = ref_run ? ~ref_clk_in : 1'b0;
  clri_int_status #(.REF_PERIOD_CYC(P)) DUT (.clk_sys(clk_sys), .nrst(nrst), .acc(acc),
    .reg_rdata(reg_rdata), .ref_clk_in(ref_clk_in), .operating_mode(operating_mode),
    .third_clock_input_valid(third_clock_input_valid),
    .readback_loop_select(readback_loop_select), .loop_freq(loop_freq),
    .status_flags(status_flags));
  // byte compare, counted
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // one-cycle write strobe, then one idle cycle
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    acc.addr = a;
    acc.wdata = d;
    acc.wr = 1'b1;
    cyc(1);
    acc.wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    acc.addr = a;
    cyc(1);
    d = reg_rdata;
  endtask
  // reset gives the reset byte, no false mode event after release
  task automatic t_reset(input logic [2:0] m);
    operating_mode = m;
    nrst = 1'b0;
    cyc(10);
    chk("status", 8'h3F, status_flags);
    chk("rdata", 8'h00, reg_rdata);
    nrst = 1'b1;
    cyc(3);
    chk("status", 8'h3F, status_flags);
    wr(7'h06, 8'hFF);
    rd(7'h06, rv);
    chk("rdata", 8'h3E, rv);
  endtask
  // validity edges latch bit 0; zero writes do nothing
  task automatic t_third();
    third_clock_input_valid = 1'b1;
    cyc(2);
    chk("status", 8'h3F, status_flags);
    wr(7'h06, 8'h00);
    chk("status", 8'h3F, status_flags);
    wr(7'h06, 8'h01);
    rd(7'h06, rv);
    chk("rdata", 8'h3E, rv);
    third_clock_input_valid = 1'b0;
    cyc(2);
    chk("status", 8'h3F, status_flags);
    wr(7'h06, 8'h01);
  endtask
  // mode change latches bit 7
  task automatic t_mode();
    operating_mode = 3'h3;
    cyc(2);
    chk("status", 8'hBE, status_flags);
    wr(7'h06, 8'h7F);
    chk("status", 8'hBE, status_flags);
    wr(7'h06, 8'h80);
    chk("status", 8'h3E, status_flags);
    operating_mode = 3'h0;
    cyc(2);
    chk("status", 8'hBE, status_flags);
    wr(7'h06, 8'h80);
  endtask
  // reference stops: flag after two missing cycles, not before
  task automatic t_loss();
    ref_run = 1'b0;
    cyc(10);
    chk("status", 8'h3E, status_flags);
    for (int i = 0; i < 30 && status_flags[6] !== 1'b1; i++) cyc(1);
    chk("lost flag", 8'h01, {7'h00, status_flags[6]});
    ref_run = 1'b1;
    cyc(3 * P);
    chk("status", 8'h7E, status_flags);
    wr(7'h06, 8'h40);
    chk("status", 8'h3E, status_flags);
  endtask
  // no loss event in free-run or holdover
  task automatic t_blocked(input logic [2:0] m);
    operating_mode = m;
    cyc(2);
    wr(7'h06, 8'h80);
    ref_run = 1'b0;
    cyc(40);
    chk("status", 8'h3E, status_flags);
    ref_run = 1'b1;
    cyc(3 * P);
    operating_mode = 3'h0;
    cyc(2);
    wr(7'h06, 8'h80);
    chk("status", 8'h3E, status_flags);
  endtask
  // readback follows the select; writes and unused bits have no effect
  task automatic t_readback();
    loop_freq = '{first_loop: 3'h7, second_loop: 3'h2};
    readback_loop_select = 1'b1;
    rd(7'h07, rv);
    chk("freq", 8'h07, rv);
    readback_loop_select = 1'b0;
    wr(7'h07, 8'hFF);
    rd(7'h07, rv);
    chk("freq", 8'h02, rv);
    chk("status", 8'h3E, status_flags);
    rd(7'h10, rv);
    chk("rdata", 8'h00, rv);
  endtask
  initial begin
    t_reset(3'h0);
    t_third();
    t_mode();
    t_reset(3'h3);
    t_loss();
    t_blocked(3'h1);
    t_blocked(3'h2);
    t_readback();
    tally_and_finish();
  end
endmodule
